// *** pkg/flash_host_regs.svh ***
`ifndef FLASH_HOST_REGS_SVH
`define FLASH_HOST_REGS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define REG_CTRL 8'h00
`define REG_ADDR 8'h04
`define REG_WDATA 8'h08
`define REG_RDATA 8'h0c
`define REG_STATUS 8'h10

`define CTRL_START 0
`define CTRL_CMD_LO 1
`define CTRL_CMD_HI 2
`define CTRL_BYTE 3
`define CTRL_HWRST 4
`define CTRL_HVUNP 5

`define STAT_BUSY 0
`define STAT_DONE 1
`define STAT_ERR 2
`define STAT_AUTOSEL 3
`define STAT_READY 4

`define CMD_CODE_READ 2'h0
`define CMD_CODE_RESET 2'h1
`define CMD_CODE_PROGRAM 2'h2
`define CMD_CODE_AUTOSEL 2'h3

// ----------------------------------------------------------------
// Flash command cycles
// ----------------------------------------------------------------
`define RESET_DATA 8'hf0
`define UNLOCK1_ADDR 18'h00000
`define UNLOCK1_DATA 8'h00
`define UNLOCK2_ADDR 18'h00000
`define UNLOCK2_DATA 8'h00
`define PROG_SETUP_ADDR 18'h00000
`define PROG_SETUP_DATA 8'h00
`define AUTOSEL_ADDR 18'h00000
`define AUTOSEL_DATA 8'h00
`define DATA_POLL_BIT 7
`define TIMEOUT_ERR_BIT 5

// ----------------------------------------------------------------
// Bus cycle timing
// ----------------------------------------------------------------
`define MCLK_PERIOD_NS 4
`define ADDR_SETUP_NS 10
`define STROBE_NS 50
`define READ_ACCESS_NS 120
`define HOLD_NS 20
`define NS_TO_CYC(ns) (8'(((ns) + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS))
`define ADDR_SETUP_CYC `NS_TO_CYC(`ADDR_SETUP_NS)
`define STROBE_CYC `NS_TO_CYC(`STROBE_NS)
`define READ_ACCESS_CYC `NS_TO_CYC(`READ_ACCESS_NS)
`define HOLD_CYC `NS_TO_CYC(`HOLD_NS)

`endif

// *** pkg/flash_host_pkg.sv ***
`default_nettype none
package flash_host_pkg;
  typedef enum logic [1:0] {CMD_READ, CMD_RESET, CMD_PROGRAM, CMD_AUTOSEL} flash_cmd_e;
  typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_DECIDE} seq_state_e;
  typedef struct packed {
    logic isRead;
    logic [17:0] addr;
    logic [15:0] data;
  } bus_step_s;
endpackage
`default_nettype wire

// *** logic/bus_phase_timer.sv ***
`timescale 1ns/1ns
`default_nettype none
module bus_phase_timer
  import flash_host_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic load,
  input wire logic [7:0] loadVal,
  output logic expire
);
  logic [7:0] count_r;
  logic running_r;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      count_r <= 8'h00;
      running_r <= 1'b0;
      expire <= 1'b0;
    end else begin
      expire <= 1'b0;
      if (load) begin
        count_r <= loadVal;
        running_r <= 1'b1;
      end else if (running_r) begin
        if (count_r <= 8'h01) begin
          expire <= 1'b1;
          running_r <= 1'b0;
        end else begin
          count_r <= count_r - 8'h01;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** logic/nor_flash_command_fsm.sv ***
// Added by the designer: register access over APB and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "flash_host_regs.svh"
module nor_flash_command_fsm
  import flash_host_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic flashCeN,
  output logic flashWeN,
  output logic flashOeN,
  output logic [17:0] flashAddr,
  output logic [15:0] flashDqOut,
  output logic flashDqOeN,
  input wire logic [15:0] flashDqIn,
  output logic flashByteN,
  output logic flashResetN,
  output logic highIdentVoltageEn,
  input wire logic opDoneIndicatorN
);
  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [1:0] cmdCode_r;
  logic byteMode_r;
  logic hwReset_r;
  logic hvUnprotect_r;
  logic [17:0] tgtAddr_r;
  logic [15:0] tgtData_r;
  logic [15:0] rdData_r;
  logic done_r;
  logic err_r;
  logic autoselMode_r;
  logic startReq_r;
  logic doneEvent;
  logic errEvent;
  logic apbWrite;
  seq_state_e state_r;

  assign apbWrite = psel && penable && pwrite && pready && !pslverr;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      if (psel && !penable) begin
        case (paddr)
          `REG_CTRL: prdata <= {26'h0000000, hvUnprotect_r, hwReset_r, byteMode_r, cmdCode_r, 1'b0};
          `REG_ADDR: prdata <= {14'h0000, tgtAddr_r};
          `REG_WDATA: prdata <= {16'h0000, tgtData_r};
          `REG_RDATA: prdata <= {16'h0000, rdData_r};
          `REG_STATUS: prdata <= {27'h0000000, !opDoneIndicatorN, autoselMode_r, err_r, done_r,
                                  state_r != ST_IDLE};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cmdCode_r <= `CMD_CODE_READ;
      byteMode_r <= 1'b0;
      hwReset_r <= 1'b0;
      hvUnprotect_r <= 1'b0;
      tgtAddr_r <= 18'h00000;
      tgtData_r <= 16'h0000;
      startReq_r <= 1'b0;
    end else begin
      startReq_r <= 1'b0;
      if (apbWrite && paddr == `REG_CTRL) begin
        cmdCode_r <= pwdata[`CTRL_CMD_HI:`CTRL_CMD_LO];
        byteMode_r <= pwdata[`CTRL_BYTE];
        hwReset_r <= pwdata[`CTRL_HWRST];
        hvUnprotect_r <= pwdata[`CTRL_HVUNP];
        startReq_r <= pwdata[`CTRL_START];
      end
      if (apbWrite && paddr == `REG_ADDR) begin
        tgtAddr_r <= pwdata[17:0];
      end
      if (apbWrite && paddr == `REG_WDATA) begin
        tgtData_r <= pwdata[15:0];
      end
    end
  end

  // Sticky flags: a new event beats a same-cycle clear
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      done_r <= 1'b0;
      err_r <= 1'b0;
    end else begin
      done_r <= doneEvent || (done_r && !(apbWrite && paddr == `REG_STATUS && pwdata[`STAT_DONE]));
      err_r <= errEvent || (err_r && !(apbWrite && paddr == `REG_STATUS && pwdata[`STAT_ERR]));
    end
  end

  // ----------------------------------------------------------------
  // Flash side pins
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      flashByteN <= 1'b1;
      flashResetN <= 1'b0;
      highIdentVoltageEn <= 1'b0;
    end else begin
      flashByteN <= !byteMode_r;
      flashResetN <= !hwReset_r;
      highIdentVoltageEn <= hvUnprotect_r;
    end
  end

  // ----------------------------------------------------------------
  // Command sequencer
  // ----------------------------------------------------------------
  flash_cmd_e cmd_r;
  flash_cmd_e cmdSel;
  logic [2:0] step_r;
  logic recovering_r;
  logic [2:0] wrCount_r;
  logic timerLoad_r;
  logic [7:0] timerVal_r;
  logic timerExpire;
  bus_step_s cur;

  always_comb begin
    unique case (cmdCode_r)
      `CMD_CODE_READ: cmdSel = CMD_READ;
      `CMD_CODE_RESET: cmdSel = CMD_RESET;
      `CMD_CODE_PROGRAM: cmdSel = CMD_PROGRAM;
      `CMD_CODE_AUTOSEL: cmdSel = CMD_AUTOSEL;
    endcase
  end

  // Address and data of each bus cycle in a sequence
  function automatic bus_step_s stepWord(flash_cmd_e c, logic [2:0] s, logic [17:0] a, logic [15:0] d);
    bus_step_s w;
    w = '{isRead: 1'b1, addr: a, data: 16'h0000};
    unique case (c)
      CMD_READ: w = '{isRead: 1'b1, addr: a, data: 16'h0000};
      CMD_RESET: w = '{isRead: 1'b0, addr: 18'h00000, data: {8'h00, `RESET_DATA}};
      CMD_AUTOSEL: begin
        if (s == 3'h0) w = '{isRead: 1'b0, addr: `UNLOCK1_ADDR, data: {8'h00, `UNLOCK1_DATA}};
        else if (s == 3'h1) w = '{isRead: 1'b0, addr: `UNLOCK2_ADDR, data: {8'h00, `UNLOCK2_DATA}};
        else w = '{isRead: 1'b0, addr: `AUTOSEL_ADDR, data: {8'h00, `AUTOSEL_DATA}};
      end
      CMD_PROGRAM: begin
        if (s == 3'h0) w = '{isRead: 1'b0, addr: `UNLOCK1_ADDR, data: {8'h00, `UNLOCK1_DATA}};
        else if (s == 3'h1) w = '{isRead: 1'b0, addr: `UNLOCK2_ADDR, data: {8'h00, `UNLOCK2_DATA}};
        else if (s == 3'h2) w = '{isRead: 1'b0, addr: `PROG_SETUP_ADDR, data: {8'h00, `PROG_SETUP_DATA}};
        else if (s == 3'h3) w = '{isRead: 1'b0, addr: a, data: d};
        else w = '{isRead: 1'b1, addr: a, data: 16'h0000};
      end
    endcase
    return w;
  endfunction

  assign cur = stepWord(cmd_r, step_r, tgtAddr_r, tgtData_r);
  assign doneEvent = (state_r == ST_DECIDE) && !recovering_r &&
                     ((cmd_r == CMD_READ) || (cmd_r == CMD_RESET) ||
                      (cmd_r == CMD_AUTOSEL && step_r == 3'h2) ||
                      (cmd_r == CMD_PROGRAM && step_r >= 3'h4 &&
                       rdData_r[`DATA_POLL_BIT] == tgtData_r[`DATA_POLL_BIT]));
  // Program while in autoselect is refused: the device must see a reset first
  assign errEvent = (state_r == ST_IDLE && startReq_r && cmdSel == CMD_PROGRAM && autoselMode_r) ||
                    (state_r == ST_DECIDE && recovering_r) || (state_r != ST_IDLE && hwReset_r);

  bus_phase_timer phaseTimer (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .load(timerLoad_r),
    .loadVal(timerVal_r),
    .expire(timerExpire)
  );

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      cmd_r <= CMD_READ;
      step_r <= 3'h0;
      recovering_r <= 1'b0;
      wrCount_r <= 3'h0;
      timerLoad_r <= 1'b0;
      timerVal_r <= 8'h01;
      autoselMode_r <= 1'b0;
      rdData_r <= 16'h0000;
      flashCeN <= 1'b1;
      flashWeN <= 1'b1;
      flashOeN <= 1'b1;
      flashAddr <= 18'h00000;
      flashDqOut <= 16'h0000;
      flashDqOeN <= 1'b1;
    end else begin
      timerLoad_r <= 1'b0;
      if (hwReset_r) begin
        // Pin reset aborts any sequence; device comes back in array read
        autoselMode_r <= 1'b0;
        state_r <= ST_IDLE;
        flashCeN <= 1'b1;
        flashWeN <= 1'b1;
        flashOeN <= 1'b1;
        flashDqOeN <= 1'b1;
      end else begin
        unique case (state_r)
          ST_IDLE: begin
            if (startReq_r && !(cmdSel == CMD_PROGRAM && autoselMode_r)) begin
              cmd_r <= cmdSel;
              step_r <= 3'h0;
              recovering_r <= 1'b0;
              wrCount_r <= 3'h0;
              state_r <= ST_SETUP;
              timerLoad_r <= 1'b1;
              timerVal_r <= `ADDR_SETUP_CYC;
            end
          end
          ST_SETUP: begin
            // Address and data settle with all strobes high
            flashAddr <= cur.addr;
            flashDqOut <= cur.data;
            flashDqOeN <= cur.isRead;
            if (timerExpire) begin
              flashCeN <= 1'b0;
              flashWeN <= cur.isRead;
              flashOeN <= !cur.isRead;
              state_r <= ST_STROBE;
              timerLoad_r <= 1'b1;
              timerVal_r <= cur.isRead ? `READ_ACCESS_CYC : `STROBE_CYC;
            end
          end
          ST_STROBE: begin
            if (timerExpire) begin
              if (cur.isRead) rdData_r <= flashDqIn;
              else wrCount_r <= wrCount_r + 3'h1;
              // Address and data stay put past the rising edge for the latch
              flashCeN <= 1'b1;
              flashWeN <= 1'b1;
              flashOeN <= 1'b1;
              state_r <= ST_HOLD;
              timerLoad_r <= 1'b1;
              timerVal_r <= `HOLD_CYC;
            end
          end
          ST_HOLD: begin
            if (timerExpire) begin
              flashDqOeN <= 1'b1;
              state_r <= ST_DECIDE;
            end
          end
          ST_DECIDE: begin
            state_r <= ST_SETUP;
            timerLoad_r <= 1'b1;
            timerVal_r <= `ADDR_SETUP_CYC;
            if (doneEvent || recovering_r) begin
              state_r <= ST_IDLE;
              timerLoad_r <= 1'b0;
              if (cmd_r == CMD_AUTOSEL) autoselMode_r <= 1'b1;
              if (cmd_r == CMD_RESET) autoselMode_r <= 1'b0;
            end else if (cmd_r == CMD_PROGRAM && step_r < 3'h4) begin
              step_r <= step_r + 3'h1;
            end else if (cmd_r == CMD_PROGRAM && step_r == 3'h4) begin
              // Timeout bit up: one more poll decides, since the last bit may just have flipped
              if (rdData_r[`TIMEOUT_ERR_BIT]) step_r <= 3'h5;
            end else if (cmd_r == CMD_PROGRAM) begin
              cmd_r <= CMD_RESET;
              step_r <= 3'h0;
              recovering_r <= 1'b1;
            end else begin
              step_r <= step_r + 3'h1;
            end
          end
          default: state_r <= ST_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence s_writeLow;
    !flashWeN ##1 !flashWeN;
  endsequence

  property p_write_framing;
    !flashWeN |-> (!flashCeN && flashOeN);
  endproperty
  a_write_framing: assert property (p_write_framing) else $error("write strobe without proper framing");

  property p_read_no_write;
    !flashOeN |-> flashWeN;
  endproperty
  a_read_no_write: assert property (p_read_no_write) else $error("output enable low during write");

  property p_stable_write;
    s_writeLow |-> ($stable(flashAddr) && $stable(flashDqOut) && !flashDqOeN);
  endproperty
  a_stable_write: assert property (p_stable_write) else $error("address or data moved in write pulse");

  property p_program_cycles;
    $rose(cmd_r == CMD_PROGRAM && step_r == 3'h4) |-> wrCount_r == 3'h4;
  endproperty
  a_program_cycles: assert property (p_program_cycles) else $error("program poll before four writes");

  property p_autosel_cycles;
    $rose(autoselMode_r) |-> (wrCount_r == 3'h3 && $past(cmd_r) == CMD_AUTOSEL);
  endproperty
  a_autosel_cycles: assert property (p_autosel_cycles) else $error("autoselect entered without three writes");

  property p_recover_reset;
    $rose(recovering_r) |-> ##[1:80] (!flashWeN && flashDqOut[7:0] == `RESET_DATA);
  endproperty
  a_recover_reset: assert property (p_recover_reset) else $error("no reset write after timeout error");

  property p_unlock_first;
    ($fell(flashWeN) && step_r == 3'h0 && (cmd_r == CMD_PROGRAM || cmd_r == CMD_AUTOSEL)) |->
      (flashAddr == `UNLOCK1_ADDR && flashDqOut[7:0] == `UNLOCK1_DATA);
  endproperty
  a_unlock_first: assert property (p_unlock_first) else $error("first cycle is not the unlock word");
endmodule
`default_nettype wire

// *** dv/flash_device_model.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "flash_host_regs.svh"
module flash_device_model #(
  parameter logic [15:0] MAKER_CODE = 16'h00a5, // Arbitrary value
  parameter logic [15:0] DEV_CODE = 16'h3c5a, // Arbitrary value
  parameter int PROG_NS = 3000
) (
  input wire logic ceN,
  input wire logic weN,
  input wire logic oeN,
  input wire logic [17:0] addr,
  input wire logic [15:0] dq,
  input wire logic byteN,
  input wire logic resetN,
  input wire logic hvEn,
  input wire logic [7:0] protMask,
  input wire logic failProg,
  output logic [15:0] dqOut,
  output logic busyN
);
  // ------------------------------------------------------------
  // Command decoding
  // ------------------------------------------------------------
  typedef enum logic [2:0] {S_RD, S_U1, S_U2, S_CMD3, S_PROG, S_FAIL} dev_state_e;
  dev_state_e st = S_RD;
  logic [15:0] mem [int];
  logic [17:0] latAddr;
  logic [17:0] progAddr;
  logic [15:0] progData;
  logic [15:0] rd;
  logic armed = 1'b0;
  event progEv;
  wire logic inReset = !resetN && !hvEn;

  function automatic logic [15:0] rdMem(input logic [17:0] a);
    return mem.exists(a) ? mem[a] : 16'hffff;
  endfunction

  // Arming only on a falling edge keeps strobes held low at power-up harmless
  // A held reset stands in for supply lockout: no write cycle is taken then
  always @(negedge weN or negedge ceN)
    if (!weN && !ceN && oeN && !inReset) begin
      armed = 1'b1;
      latAddr = addr;
    end

  always @(posedge weN or posedge ceN)
    if (armed) begin
      armed = 1'b0;
      if (st == S_PROG) st = st;
      else if (dq[7:0] == `RESET_DATA) st = S_RD;
      else case (st)
        S_RD: st = (latAddr == `UNLOCK1_ADDR && dq[7:0] == `UNLOCK1_DATA) ? S_U1 : S_RD;
        S_U1: st = (latAddr == `UNLOCK2_ADDR && dq[7:0] == `UNLOCK2_DATA) ? S_U2 : S_RD;
        S_U2: st = (latAddr == `PROG_SETUP_ADDR && dq[7:0] == `PROG_SETUP_DATA) ? S_CMD3 : S_RD;
        S_CMD3: begin
          progAddr = latAddr;
          progData = dq;
          if (failProg || (protMask[latAddr[17:15]] && !hvEn)) st = S_FAIL;
          else begin
            st = S_PROG;
            ->progEv;
          end
        end
        default: st = st;
      endcase
    end

  always @(negedge resetN)
    if (!hvEn) st = S_RD;

  initial forever begin
    @(progEv);
    #PROG_NS;
    if (st == S_PROG) begin
      mem[progAddr] = rdMem(progAddr) & progData;
      st = S_RD;
    end
  end

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  always @* begin
    case (st)
      S_PROG: rd = {8'h00, ~progData[7], 7'h00};
      S_FAIL: rd = {8'h00, ~progData[7], 2'b01, 5'h00};
      S_CMD3:
        if (addr[7:0] == 8'h00) rd = MAKER_CODE;
        else if (addr[7:0] == (byteN ? 8'h01 : 8'h02)) rd = DEV_CODE;
        else if (addr[7:0] == (byteN ? 8'h02 : 8'h04)) rd = {15'h0, protMask[addr[17:15]]};
        else rd = 16'h0000;
      default: rd = rdMem(addr);
    endcase
  end

  // No pull on the bus, so a released bus shows the inverse instead of a stale value
  assign dqOut = (!ceN && !oeN && !inReset) ? rd : ~rd;
  assign busyN = (st != S_PROG);
endmodule
`default_nettype wire

// *** dv/tb.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "flash_host_regs.svh"
module tb import flash_host_pkg::*;;
  // ------------------------------------------------------------
  // Bench wiring
  // ------------------------------------------------------------
  localparam logic [15:0] MAKER = 16'h00a5; // Arbitrary value
  localparam logic [15:0] DEV = 16'h3c5a; // Arbitrary value
  logic mclk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, st;
  logic pready, pslverr, flashCeN, flashWeN, flashOeN, flashDqOeN, flashByteN, flashResetN;
  logic highIdentVoltageEn, opDoneIndicatorN, sawBusyPin;
  logic [17:0] flashAddr;
  logic [15:0] flashDqOut, devDq, flashBus;
  logic [7:0] protMask = 8'h00;
  logic failProg = 1'b0;
  logic [2:0] ctrlMode = 3'h0;
  int errors = 0, samples_checked = 0;
  assign flashBus = !flashDqOeN ? flashDqOut : devDq;
  always #2 mclk = ~mclk;

  nor_flash_command_fsm nor_flash_command_fsm_i (.mclk(mclk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .flashCeN(flashCeN), .flashWeN(flashWeN), .flashOeN(flashOeN), .flashAddr(flashAddr),
    .flashDqOut(flashDqOut), .flashDqOeN(flashDqOeN), .flashDqIn(flashBus), .flashByteN(flashByteN),
    .flashResetN(flashResetN), .highIdentVoltageEn(highIdentVoltageEn), .opDoneIndicatorN(opDoneIndicatorN));
  flash_device_model #(.MAKER_CODE(MAKER), .DEV_CODE(DEV)) flash_device_model_i (.ceN(flashCeN),
    .weN(flashWeN), .oeN(flashOeN), .addr(flashAddr), .dq(flashBus), .byteN(flashByteN), .resetN(flashResetN),
    .hvEn(highIdentVoltageEn), .protMask(protMask), .failProg(failProg), .dqOut(devDq), .busyN(opDoneIndicatorN));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic err);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask

  // Polling STATUS also records whether the busy pin was ever seen low
  task automatic run(input logic [1:0] cmd, input logic [17:0] a, input logic [15:0] d, output logic [31:0] s);
    int n;
    n = 0;
    wr(`REG_ADDR, {14'h0, a});
    wr(`REG_WDATA, {16'h0, d});
    wr(`REG_CTRL, {26'h0, ctrlMode, cmd, 1'b1});
    do begin
      rd(`REG_STATUS, s);
      sawBusyPin |= s[`STAT_READY];
      n++;
    end while (s[`STAT_BUSY] !== 1'b0 && n < 2000);
    if (n >= 2000) errors++;
    wr(`REG_STATUS, 32'h6);
  endtask

  task automatic flash_read(input logic [17:0] a, input logic [15:0] exp, input string msg);
    logic [31:0] s;
    logic [31:0] q;
    run(`CMD_CODE_READ, a, 16'h0, s);
    rd(`REG_RDATA, q);
    check(q, {16'h0, exp}, msg);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic test_reset();
    logic [31:0] q;
    logic e;
    check({28'h0, flashCeN, flashWeN, flashOeN, flashResetN}, 32'he, "pins in reset");
    sys_rst <= 1'b0;
    repeat (2) @(posedge mclk);
    check({28'h0, flashCeN, flashWeN, flashOeN, flashDqOeN}, 32'hf, "pins idle");
    rd(`REG_STATUS, q);
    check(q, 32'h0, "status after reset");
    apb(1'b0, 8'h40, 32'h0, q, e);
    check({31'h0, e}, 32'h1, "unmapped address");
    flash_read(18'h00123, 16'hffff, "array read at start");
    $display("test reset done");
  endtask

  task automatic test_program();
    sawBusyPin = 1'b0;
    run(`CMD_CODE_PROGRAM, 18'h00123, 16'h5a3c, st);
    check({30'h0, st[2:1]}, 32'h1, "program done");
    check({31'h0, sawBusyPin}, 32'h1, "busy pin during program");
    flash_read(18'h00123, 16'h5a3c, "programmed word");
    run(`CMD_CODE_PROGRAM, 18'h00123, 16'hff7f, st);
    flash_read(18'h00123, 16'h5a3c, "zeros stay zero");
    $display("test program done");
  endtask

  task automatic test_protect();
    protMask <= 8'h04;
    run(`CMD_CODE_PROGRAM, 18'h10010, 16'h1234, st);
    check({30'h0, st[2:1]}, 32'h2, "protected refused");
    flash_read(18'h10010, 16'hffff, "protected unchanged");
    ctrlMode <= 3'b100;
    run(`CMD_CODE_PROGRAM, 18'h10010, 16'h1234, st);
    check({31'h0, highIdentVoltageEn}, 32'h1, "high voltage pin");
    ctrlMode <= 3'b000;
    flash_read(18'h10010, 16'h1234, "temporary unprotect");
    run(`CMD_CODE_PROGRAM, 18'h10011, 16'h1234, st);
    check({30'h0, st[2:1]}, 32'h2, "protected again");
    $display("test protect done");
  endtask

  task automatic test_autosel();
    run(`CMD_CODE_AUTOSEL, 18'h0, 16'h0, st);
    check({31'h0, st[`STAT_AUTOSEL]}, 32'h1, "autoselect entered");
    flash_read(18'h00000, MAKER, "maker code");
    flash_read(18'h00001, DEV, "device code");
    flash_read(18'h10002, 16'h0001, "sector protected");
    flash_read(18'h08002, 16'h0000, "sector unprotected");
    flash_read(18'h00000, MAKER, "maker code again");
    ctrlMode <= 3'b001;
    flash_read(18'h00002, DEV, "device code byte mode");
    check({31'h0, flashByteN}, 32'h0, "byte pin");
    flash_read(18'h10004, 16'h0001, "sector protected byte mode");
    ctrlMode <= 3'b000;
    run(`CMD_CODE_PROGRAM, 18'h00200, 16'h1111, st);
    check({30'h0, st[2:1]}, 32'h2, "program refused in autoselect");
    run(`CMD_CODE_RESET, 18'h3ffff, 16'h0, st);
    check({31'h0, st[`STAT_AUTOSEL]}, 32'h0, "autoselect left");
    flash_read(18'h00123, 16'h5a3c, "array after reset command");
    $display("test autoselect done");
  endtask

  task automatic test_timeout();
    failProg <= 1'b1;
    run(`CMD_CODE_PROGRAM, 18'h00300, 16'h00aa, st);
    failProg <= 1'b0;
    check({30'h0, st[2:1]}, 32'h2, "timeout error");
    flash_read(18'h00300, 16'hffff, "array after timeout");
    wr(`REG_CTRL, 32'h10);
    repeat (2) @(posedge mclk);
    check({31'h0, flashResetN}, 32'h0, "hardware reset pin");
    wr(`REG_CTRL, 32'h0);
    repeat (2) @(posedge mclk);
    check({31'h0, flashResetN}, 32'h1, "hardware reset released");
    $display("test timeout done");
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    sawBusyPin = 1'b0;
    repeat (12) @(posedge mclk);
    test_reset();
    test_program();
    test_protect();
    test_autosel();
    test_timeout();
    finish_test();
  end

  // Whole run needs well under a quarter of this span
  initial begin
    repeat (80000) @(posedge mclk);
    errors++;
    finish_test();
  end
endmodule
`default_nettype wire
